// ### hw/mpd_pkg.sv
// Package: register map, field layout, reset values and states of the PWM control block
package mpd_pkg;

	// Register byte offsets (one aligned 32-bit word each)
	localparam logic [7:0] ADR_UPD_CTRL  = 8'h00;
	localparam logic [7:0] ADR_DT_CFG    = 8'h04;
	localparam logic [7:0] ADR_DT_EDGE   = 8'h08;
	localparam logic [7:0] ADR_FLT_A     = 8'h0c;
	localparam logic [7:0] ADR_FLT_B     = 8'h10;
	localparam logic [7:0] ADR_OVR       = 8'h14;
	localparam logic [7:0] ADR_FLT_STAT  = 8'h18;
	localparam logic [7:0] ADR_DUTY1     = 8'h1c;
	localparam logic [7:0] ADR_DUTY2     = 8'h20;
	localparam logic [7:0] ADR_DUTY3     = 8'h24;
	localparam logic [7:0] ADR_DUTY4     = 8'h28;

	// Implemented-bit masks; all other bits read zero
	localparam logic [15:0] MASK_UPD_CTRL = 16'h0f07;
	localparam logic [15:0] MASK_DT_CFG   = 16'hffff;
	localparam logic [15:0] MASK_DT_EDGE  = 16'h00ff;
	localparam logic [15:0] MASK_FLT      = 16'hff8f;
	localparam logic [15:0] MASK_OVR      = 16'hffff;
	localparam logic [15:0] MASK_DUTY     = 16'hffff;

	// Reset values
	localparam logic [15:0] RST_ZERO      = 16'h0000;
	localparam logic [15:0] RST_OVR       = 16'hff00;

	// Update control fields
	localparam int UPD_POST_LSB   = 8;
	localparam int UPD_IMM_BIT    = 2;
	localparam int UPD_OVERRIDE_SYNC_SEL_BIT  = 1;
	localparam int UPD_INHIBIT_BIT = 0;

	// Dead-time configuration fields
	localparam int DT_B_PS_LSB    = 14;
	localparam int DT_B_CNT_LSB   = 8;
	localparam int DT_A_PS_LSB    = 6;
	localparam int DT_A_CNT_LSB   = 0;

	// Fault and override fields
	localparam int FLT_VAL_LSB    = 8;
	localparam int FLT_MODE_BIT   = 7;
	localparam int OVR_GEN_LSB    = 8;

	// Fault status fields
	localparam int STAT_A_BIT     = 0;
	localparam int STAT_B_BIT     = 1;
	localparam int STAT_PIN_A_BIT = 2;
	localparam int STAT_PIN_B_BIT = 3;

	// Dead-time channel states
	typedef enum logic [0:0] {
		dt_idle = 1'b0,
		dt_wait = 1'b1
	} mpd_dt_state_t;

endpackage

// ### hw/mpd_postscaler.sv
// Special event trigger postscaler: one trigger per selected number of events
module mpd_postscaler #(
	parameter int SEL_W = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             event_i,
	input  wire logic [SEL_W-1:0] sel_i,
	output logic                  trig_o
);

	logic [SEL_W-1:0] cnt_reg;
	logic             trig_reg;
	wire              wrap = (cnt_reg >= sel_i);

	// Count events, fire on the last one of each group
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg  <= '0;
			trig_reg <= 1'b0;
		end else if (ce_i) begin
			trig_reg <= event_i & wrap;
			if (event_i) begin
				cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
			end
		end
	end

	assign trig_o = trig_reg;

endmodule

// ### hw/mpd_deadtime_ch.sv
// One complementary channel: blanks both outputs for the dead time at each edge
module mpd_deadtime_ch #(
	parameter int LEN_W = 9
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             gen_i,
	input  wire logic [LEN_W-1:0] len_on_i,
	input  wire logic [LEN_W-1:0] len_off_i,
	output logic                  high_o,
	output logic                  low_o
);

	mpd_pkg::mpd_dt_state_t state_reg;
	logic [LEN_W-1:0]       cnt_reg;
	logic                   gen_q_reg;

	wire              edge_seen = (gen_i != gen_q_reg);
	wire [LEN_W-1:0]  len_sel   = gen_i ? len_on_i : len_off_i;

	// Restart the blanking on every generator edge, even mid-wait
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= mpd_pkg::dt_idle;
			cnt_reg   <= '0;
			gen_q_reg <= 1'b0;
		end else if (ce_i) begin
			gen_q_reg <= gen_i;
			case (state_reg)
				mpd_pkg::dt_idle: begin
					if (edge_seen && len_sel != '0) begin
						state_reg <= mpd_pkg::dt_wait;
						cnt_reg   <= len_sel;
					end
				end
				mpd_pkg::dt_wait: begin
					if (edge_seen) begin
						state_reg <= (len_sel != '0) ? mpd_pkg::dt_wait : mpd_pkg::dt_idle;
						cnt_reg   <= len_sel;
					end else if (cnt_reg == 1) begin
						state_reg <= mpd_pkg::dt_idle;
						cnt_reg   <= '0;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= mpd_pkg::dt_idle;
				end
			endcase
		end
	end

	// Both sides stay off while blanking
	assign high_o = (state_reg == mpd_pkg::dt_idle) & gen_q_reg;
	assign low_o  = (state_reg == mpd_pkg::dt_idle) & ~gen_q_reg;

endmodule

// ### hw/mpd_top.sv
// PWM control: update policy, dead time, fault and manual override, Wishbone slave
// Summary of operation
// RQ1 - Trigger postscale divides compare events by 1..16
// RQ2 - Immediate bit makes duty writes active at once
// RQ3 - Override sync bit aligns overrides to time base
// RQ4 - Inhibit bit blocks buffer to active transfers
// RQ5 - Unit B dead-time clock period 1,2,4,8 cycles
// RQ6 - Unit B six-bit dead-time count
// RQ7 - Unit A dead-time clock period 1,2,4,8 cycles
// RQ8 - Unit A six-bit dead-time count
// RQ9 - Per-channel edge bits pick unit B or A
// RQ10 - Fault A drives outputs to its override values
// RQ11 - Fault A mode: cycle-by-cycle or latched
// RQ12 - Per-pair enables place pairs under fault A
// RQ13 - Fault B drives outputs to its override values
// RQ14 - Fault B mode: cycle-by-cycle or latched
// RQ15 - Per-pair enables place pairs under fault B
// RQ16 - Fault A wins over fault B
// RQ17 - Override bit selects generator or manual level
// RQ18 - Manual level drives pin active or inactive
// RQ19 - Pair mode bit: independent or complementary
// RQ20 - Complementary pairs blank for selected dead time
// RQ21 - Unimplemented bits ignore writes, read zero
module mpd_top #(
	parameter int NCH    = 4,
	parameter int DUTY_W = 16
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	input  wire logic [3:0]            wb_sel_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  tb_sync_i,
	input  wire logic                  sevt_match_i,
	input  wire logic [NCH-1:0]        gen_high_i,
	input  wire logic [NCH-1:0]        gen_low_i,
	input  wire logic [NCH-1:0]        pair_independent_sel_i,
	input  wire logic                  fault_input_first_i,
	input  wire logic                  fault_input_second_i,
	output logic      [NCH-1:0]        pair_high_o,
	output logic      [NCH-1:0]        pair_low_o,
	output logic      [NCH*DUTY_W-1:0] duty_value_o,
	output logic                       period_load_o,
	output logic                       special_trigger_o
);

	// Control registers
	logic [15:0] upd_ctrl_reg;
	logic [15:0] dt_cfg_reg;
	logic [15:0] dt_edge_reg;
	logic [15:0] flt_a_reg;
	logic [15:0] flt_b_reg;
	logic [15:0] manual_override_reg;
	logic [15:0] ovr_eff_reg;
	logic [DUTY_W-1:0] duty_buf_reg [NCH];
	logic [DUTY_W-1:0] duty_act_reg [NCH];
	logic        flt_a_act_reg;
	logic        flt_b_act_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [NCH-1:0] high_out_reg;
	logic [NCH-1:0] low_out_reg;
	logic        period_load_reg;

	// Bus request decode
	wire         req      = wb_cyc_i & wb_stb_i;
	wire         wr_fire  = req & wb_we_i & ack_reg;
	wire [7:0]   adr_w    = {wb_adr_i[7:2], 2'b00};
	wire [15:0]  lane_m   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [15:0]  wr_bits  = wb_dat_i[15:0];

	wire hit_upd   = (adr_w == mpd_pkg::ADR_UPD_CTRL);
	wire hit_dtc   = (adr_w == mpd_pkg::ADR_DT_CFG);
	wire hit_dte   = (adr_w == mpd_pkg::ADR_DT_EDGE);
	wire hit_fa    = (adr_w == mpd_pkg::ADR_FLT_A);
	wire hit_fb    = (adr_w == mpd_pkg::ADR_FLT_B);
	wire hit_ovr   = (adr_w == mpd_pkg::ADR_OVR);
	wire hit_stat  = (adr_w == mpd_pkg::ADR_FLT_STAT);
	wire [NCH-1:0] hit_duty;

	// Duty registers sit on consecutive words
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_duty_dec
			assign hit_duty[g] = (adr_w == 8'(mpd_pkg::ADR_DUTY1 + 8'(4 * g)));
		end
	endgenerate

	// Control field taps
	wire [3:0] trigger_postscale_sel = upd_ctrl_reg[mpd_pkg::UPD_POST_LSB +: 4];
	wire       immediate_duty_update = upd_ctrl_reg[mpd_pkg::UPD_IMM_BIT];
	wire       override_sync_sel     = upd_ctrl_reg[mpd_pkg::UPD_OVERRIDE_SYNC_SEL_BIT];
	wire       buffer_update_inhibit = upd_ctrl_reg[mpd_pkg::UPD_INHIBIT_BIT];
	wire [1:0] deadtime_b_prescale   = dt_cfg_reg[mpd_pkg::DT_B_PS_LSB +: 2];
	wire [5:0] deadtime_b_count      = dt_cfg_reg[mpd_pkg::DT_B_CNT_LSB +: 6];
	wire [1:0] deadtime_a_prescale   = dt_cfg_reg[mpd_pkg::DT_A_PS_LSB +: 2];
	wire [5:0] deadtime_a_count      = dt_cfg_reg[mpd_pkg::DT_A_CNT_LSB +: 6];
	wire       fault_a_cycle_mode    = flt_a_reg[mpd_pkg::FLT_MODE_BIT];
	wire       fault_b_cycle_mode    = flt_b_reg[mpd_pkg::FLT_MODE_BIT];
	wire [NCH-1:0] fault_a_pair_en   = flt_a_reg[NCH-1:0];
	wire [NCH-1:0] fault_b_pair_en   = flt_b_reg[NCH-1:0];

	// Write merge honours byte lanes and drops unimplemented bits
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] msk,
		input logic [15:0] lanes, input logic [15:0] d);
		merge = ((old & ~lanes) | (d & lanes)) & msk;
	endfunction

	// Update control register
	// RQ21 masked write storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upd_ctrl_reg <= mpd_pkg::RST_ZERO;
		end else if (ce_i && wr_fire && hit_upd) begin
			upd_ctrl_reg <= merge(upd_ctrl_reg, mpd_pkg::MASK_UPD_CTRL, lane_m, wr_bits);
		end
	end

	// Dead-time configuration and edge selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dt_cfg_reg  <= mpd_pkg::RST_ZERO;
			dt_edge_reg <= mpd_pkg::RST_ZERO;
		end else if (ce_i && wr_fire) begin
			if (hit_dtc) dt_cfg_reg <= merge(dt_cfg_reg, mpd_pkg::MASK_DT_CFG, lane_m, wr_bits);
			if (hit_dte) dt_edge_reg <= merge(dt_edge_reg, mpd_pkg::MASK_DT_EDGE, lane_m, wr_bits);
		end
	end

	// Fault control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flt_a_reg <= mpd_pkg::RST_ZERO;
			flt_b_reg <= mpd_pkg::RST_ZERO;
		end else if (ce_i && wr_fire) begin
			if (hit_fa) flt_a_reg <= merge(flt_a_reg, mpd_pkg::MASK_FLT, lane_m, wr_bits);
			if (hit_fb) flt_b_reg <= merge(flt_b_reg, mpd_pkg::MASK_FLT, lane_m, wr_bits);
		end
	end

	// Manual override: software copy and the copy the pins follow
	// RQ3 override apply timing
	wire ovr_apply = override_sync_sel ? tb_sync_i : 1'b1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			manual_override_reg <= mpd_pkg::RST_OVR;
			ovr_eff_reg         <= mpd_pkg::RST_OVR;
		end else if (ce_i) begin
			if (wr_fire && hit_ovr) begin
				manual_override_reg <= merge(manual_override_reg, mpd_pkg::MASK_OVR,
					lane_m, wr_bits);
			end
			if (ovr_apply) begin
				ovr_eff_reg <= manual_override_reg;
			end
		end
	end

	// Duty buffers and active copies, one pair per channel
	// RQ4 inhibit gates every transfer
	wire xfer_ok = ~buffer_update_inhibit;

	generate
		for (g = 0; g < NCH; g++) begin : g_duty
			wire [DUTY_W-1:0] buf_new = merge(duty_buf_reg[g], mpd_pkg::MASK_DUTY,
				lane_m, wr_bits);
			wire              wr_here = wr_fire & hit_duty[g];

			// RQ2 immediate or period-aligned update
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					duty_buf_reg[g] <= '0;
					duty_act_reg[g] <= '0;
				end else if (ce_i) begin
					if (wr_here) begin
						duty_buf_reg[g] <= buf_new;
					end
					if (wr_here && immediate_duty_update && xfer_ok) begin
						duty_act_reg[g] <= buf_new;
					end else if (tb_sync_i && xfer_ok) begin
						duty_act_reg[g] <= duty_buf_reg[g];
					end
				end
			end

			assign duty_value_o[g*DUTY_W +: DUTY_W] = duty_act_reg[g];
		end
	endgenerate

	// Period buffer load strobe for the time base
	// RQ4 period transfer inhibit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			period_load_reg <= 1'b0;
		end else if (ce_i) begin
			period_load_reg <= tb_sync_i & xfer_ok;
		end
	end

	// Fault status clear by writing ones to the status word
	wire clr_a = wr_fire & hit_stat & wb_sel_i[0] & wb_dat_i[mpd_pkg::STAT_A_BIT];
	wire clr_b = wr_fire & hit_stat & wb_sel_i[0] & wb_dat_i[mpd_pkg::STAT_B_BIT];

	// Cycle-by-cycle faults end at a period start, latched ones by software;
	// a fault pin still asserted always wins over the clear
	// RQ11 fault A mode
	wire flt_a_end = fault_a_cycle_mode ? tb_sync_i : clr_a;
	// RQ14 fault B mode
	wire flt_b_end = fault_b_cycle_mode ? tb_sync_i : clr_b;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flt_a_act_reg <= 1'b0;
			flt_b_act_reg <= 1'b0;
		end else if (ce_i) begin
			if (fault_input_first_i) begin
				flt_a_act_reg <= 1'b1;
			end else if (flt_a_end) begin
				flt_a_act_reg <= 1'b0;
			end
			if (fault_input_second_i) begin
				flt_b_act_reg <= 1'b1;
			end else if (flt_b_end) begin
				flt_b_act_reg <= 1'b0;
			end
		end
	end

	// Dead-time lengths in clock cycles: count scaled by the unit's period
	// RQ5 unit B prescale
	// RQ6 unit B count
	wire [8:0] dtb_len = 9'({3'h0, deadtime_b_count} << deadtime_b_prescale);
	// RQ7 unit A prescale
	// RQ8 unit A count
	wire [8:0] dta_len = 9'({3'h0, deadtime_a_count} << deadtime_a_prescale);

	// Per-channel output path
	logic [NCH-1:0] high_next;
	logic [NCH-1:0] low_next;

	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			wire       cmp_high;
			wire       cmp_low;
			// RQ9 edge unit select
			wire [8:0] len_on  = dt_edge_reg[2*g+1] ? dtb_len : dta_len;
			wire [8:0] len_off = dt_edge_reg[2*g] ? dtb_len : dta_len;

			// RQ20 complementary blanking
			mpd_deadtime_ch #(
				.LEN_W (9)
			) u_dt (
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.ce_i      (ce_i),
				.gen_i     (gen_high_i[g]),
				.len_on_i  (len_on),
				.len_off_i (len_off),
				.high_o    (cmp_high),
				.low_o     (cmp_low)
			);

			// RQ19 independent or complementary
			wire gen_h = pair_independent_sel_i[g] ? gen_high_i[g] : cmp_high;
			wire gen_l = pair_independent_sel_i[g] ? gen_low_i[g] : cmp_low;

			// RQ17 generator or manual source
			// RQ18 manual level
			wire man_h = ovr_eff_reg[mpd_pkg::OVR_GEN_LSB + 2*g + 1] ? gen_h
				: ovr_eff_reg[2*g+1];
			wire man_l = ovr_eff_reg[mpd_pkg::OVR_GEN_LSB + 2*g] ? gen_l
				: ovr_eff_reg[2*g];

			// RQ12 fault A pair enable
			wire fa_on = flt_a_act_reg & fault_a_pair_en[g];
			// RQ15 fault B pair enable
			wire fb_on = flt_b_act_reg & fault_b_pair_en[g];

			// RQ10 fault A values
			// RQ13 fault B values
			// RQ16 fault A priority
			assign high_next[g] = fa_on ? flt_a_reg[mpd_pkg::FLT_VAL_LSB + 2*g + 1]
				: fb_on ? flt_b_reg[mpd_pkg::FLT_VAL_LSB + 2*g + 1] : man_h;
			assign low_next[g]  = fa_on ? flt_a_reg[mpd_pkg::FLT_VAL_LSB + 2*g]
				: fb_on ? flt_b_reg[mpd_pkg::FLT_VAL_LSB + 2*g] : man_l;
		end
	endgenerate

	// Pin levels leave from flops to keep glitches off the gate drivers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_out_reg <= '0;
			low_out_reg  <= '0;
		end else if (ce_i) begin
			high_out_reg <= high_next;
			low_out_reg  <= low_next;
		end
	end

	// RQ1 trigger postscale
	mpd_postscaler #(
		.SEL_W (4)
	) u_post (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.event_i (sevt_match_i),
		.sel_i   (trigger_postscale_sel),
		.trig_o  (special_trigger_o)
	);

	// Read selection; unmapped words read zero
	wire [NCH-1:0] stat_bits = {fault_input_second_i, fault_input_first_i,
		flt_b_act_reg, flt_a_act_reg};
	logic [15:0] duty_rd;

	always_comb begin
		duty_rd = '0;
		for (int k = 0; k < NCH; k++) begin
			if (hit_duty[k]) duty_rd = duty_buf_reg[k];
		end
	end

	// RQ21 unimplemented bits read zero
	wire [15:0] rd_word =
		hit_upd  ? upd_ctrl_reg :
		hit_dtc  ? dt_cfg_reg :
		hit_dte  ? dt_edge_reg :
		hit_fa   ? flt_a_reg :
		hit_fb   ? flt_b_reg :
		hit_ovr  ? manual_override_reg :
		hit_stat ? {12'h000, stat_bits} :
		duty_rd;

	// Single-wait-state answer; ack drops the cycle after it rose,
	// so back-to-back requests see one idle edge between answers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_reg   <= req & ~ack_reg;
			rdata_reg <= (req & ~ack_reg) ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	assign wb_ack_o      = ack_reg;
	assign wb_dat_o      = rdata_reg;
	assign pair_high_o   = high_out_reg;
	assign pair_low_o    = low_out_reg;
	assign period_load_o = period_load_reg;

endmodule

// ### tb/mpd_props.sv
// Port-level checker for the PWM control block
module mpd_props #(
	parameter int NCH    = 4,
	parameter int DUTY_W = 16
) (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  ce_i,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [7:0]            wb_adr_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	input wire logic                  tb_sync_i,
	input wire logic                  sevt_match_i,
	input wire logic                  fault_input_first_i,
	input wire logic [NCH-1:0]        pair_high_o,
	input wire logic [NCH-1:0]        pair_low_o,
	input wire logic [NCH*DUTY_W-1:0] duty_value_o,
	input wire logic                  period_load_o,
	input wire logic                  special_trigger_o
);
	logic [15:0] fa_reg;
	logic [3:0]  fa_h;
	logic [3:0]  fa_l;

	// Shadow of fault A setup, taken where the write lands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fa_reg <= 16'h0000;
		end else if (wb_ack_o && wb_we_i && wb_adr_i[7:2] == mpd_pkg::ADR_FLT_A[7:2]) begin
			fa_reg <= wb_dat_i[15:0];
		end
	end

	// Value byte order is 4H,4L,...,1H,1L
	assign fa_h = {fa_reg[15], fa_reg[13], fa_reg[11], fa_reg[9]};
	assign fa_l = {fa_reg[14], fa_reg[12], fa_reg[10], fa_reg[8]};

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack high two cycles");

	property p_ack_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acked in one cycle");

	property p_idle_zero;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data not zero outside ack");

	property p_upper_zero;
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("unused bits read nonzero");

	property p_load_cause;
		period_load_o |-> $past(tb_sync_i);
	endproperty
	a_load_cause: assert property (p_load_cause) else $error("period load without sync");

	property p_trig_cause;
		special_trigger_o |-> $past(sevt_match_i);
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger without match");

	property p_fault_a;
		fault_input_first_i && fa_reg[3:0] == 4'hf |-> ##2 pair_high_o == fa_h && pair_low_o == fa_l;
	endproperty
	a_fault_a: assert property (p_fault_a) else $error("fault A values not driven");

	property p_reset_clear;
		$fell(rst_i) |-> !wb_ack_o && pair_high_o == 4'h0 && pair_low_o == 4'h0 && duty_value_o == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");

	c_write: cover property (wb_ack_o && wb_we_i);
	c_trig: cover property (special_trigger_o);
	c_fault: cover property (fault_input_first_i && fa_reg[3:0] == 4'hf);
endmodule

bind mpd_top mpd_props #(.NCH(NCH), .DUTY_W(DUTY_W)) mpd_props_inst (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .tb_sync_i(tb_sync_i), .sevt_match_i(sevt_match_i),
	.fault_input_first_i(fault_input_first_i), .pair_high_o(pair_high_o),
	.pair_low_o(pair_low_o), .duty_value_o(duty_value_o), .period_load_o(period_load_o),
	.special_trigger_o(special_trigger_o));

// ### tb/mpd_stage_model.sv
// Power stage stand-in: fault comparators and a shoot-through watch
module mpd_stage_model (
	input  wire logic       clk_i,
	input  wire logic       req_a_i,
	input  wire logic       req_b_i,
	input  wire logic [3:0] high_i,
	input  wire logic [3:0] low_i,
	input  wire logic [3:0] indep_i,
	output logic            fault_a_o,
	output logic            fault_b_o,
	output logic [3:0]      shoot_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Comparators are synchronous, so they switch just after an edge
	initial begin
		fault_a_o = 1'b0;
		fault_b_o = 1'b0;
	end
	always @(posedge clk_i) begin
		fault_a_o <= req_a_i;
		fault_b_o <= req_b_i;
	end

	// Both switches of a complementary leg on would short the rail
	assign shoot_o = high_i & low_i & ~indep_i;
endmodule

// ### tb/mpd_top_tb_top.sv
// Self-checking bench for the PWM control block
module mpd_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_i, rst_i, cyc, stb, we, tbs, sevt, fa_req, fb_req, ack, fa, fb, pload, trig;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, q;
	logic [3:0]  gh, gl, ind, ph, pl, shoot, sel;
	logic [63:0] duty;
	int          bad_count, n_tests, trig_n, load_n, n0, k;
	logic [7:0]  radr [6] = '{mpd_pkg::ADR_UPD_CTRL, mpd_pkg::ADR_DT_CFG, mpd_pkg::ADR_DT_EDGE,
		mpd_pkg::ADR_FLT_A, mpd_pkg::ADR_FLT_B, mpd_pkg::ADR_OVR};
	logic [15:0] rmsk [6] = '{16'h0f07, 16'hffff, 16'h00ff, 16'hff8f, 16'hff8f, 16'hffff};
	logic [15:0] rrst [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hff00};
	logic [15:0] dcfg [4] = '{16'h0000, 16'h0043, 16'h00c2, 16'h8500};
	logic [7:0]  dedg [4] = '{8'h00, 8'h00, 8'h00, 8'h02};

	mpd_top mpd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .tb_sync_i(tbs), .sevt_match_i(sevt),
		.gen_high_i(gh), .gen_low_i(gl), .pair_independent_sel_i(ind),
		.fault_input_first_i(fa), .fault_input_second_i(fb), .pair_high_o(ph),
		.pair_low_o(pl), .duty_value_o(duty), .period_load_o(pload), .special_trigger_o(trig));

	mpd_stage_model mpd_stage_model_inst (.clk_i(clk_i), .req_a_i(fa_req), .req_b_i(fb_req),
		.high_i(ph), .low_i(pl), .indep_i(ind), .fault_a_o(fa), .fault_b_o(fb), .shoot_o(shoot));

	// Free-running clock, 5 ns period
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Pulse counters; tests compare differences so no reset race
	always @(posedge clk_i) begin
		if (trig === 1'b1) trig_n++;
		if (pload === 1'b1) load_n++;
	end

	task automatic give_verdict();
		if (bad_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One classic cycle; holds until ack is sampled, bounded wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		wdat <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		// A missing answer ends the run through the verdict
		if (n >= 40) begin
			bad_count++;
			give_verdict();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 16'h0000);
		chk_val(q, {16'h0000, e});
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// One-cycle pulse on the period sync or on the compare match
	task automatic pulse(input bit is_sync);
		@(posedge clk_i);
		if (is_sync) tbs <= 1'b1;
		else sevt <= 1'b1;
		@(posedge clk_i);
		tbs <= 1'b0;
		sevt <= 1'b0;
	endtask

	task automatic req(input logic a, input logic b);
		@(posedge clk_i);
		fa_req <= a;
		fb_req <= b;
		waitc(5);
	endtask

	// Bounded guard against a hung handshake
	initial begin
		waitc(20000);
		bad_count++;
		give_verdict();
	end

	// Main sequence
	initial begin
		{rst_i, cyc, stb, we, tbs, sevt, fa_req, fb_req} = 8'h80;
		{adr, wdat, gh, gl, ind, sel} = '0;
		waitc(6);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(radr[i], rrst[i]);
			wr(radr[i], 16'hffff);
			rd(radr[i], rmsk[i]);
			wr(radr[i], rrst[i]);
		end
		wr(8'h3c, 16'hffff);
		rd(8'h3c, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			wr(mpd_pkg::ADR_DT_CFG, dcfg[i]);
			wr(mpd_pkg::ADR_DT_EDGE, {8'h00, dedg[i]});
			n0 = dedg[i][1] ? int'(dcfg[i][13:8]) << dcfg[i][15:14] : int'(dcfg[i][5:0]) << dcfg[i][7:6];
			@(posedge clk_i);
			gh <= 4'h1;
			k = 0;
			do begin
				@(posedge clk_i);
				k++;
			end while (ph[0] !== 1'b1 && k < 200);
			chk_cnt(k, n0 + 3);
			chk_val({shoot, pl[0]}, 0);
			gh <= 4'h0;
			waitc(60);
		end
		for (int c = 0; c < 16; c = c * 4 + 3) begin
			wr(mpd_pkg::ADR_UPD_CTRL, 16'(c << 8));
			n0 = trig_n;
			repeat (48) pulse(1'b0);
			waitc(3);
			chk_cnt(trig_n - n0, 48 / (c + 1));
		end
		wr(mpd_pkg::ADR_UPD_CTRL, 16'h0004);
		wr(mpd_pkg::ADR_DUTY1, 16'h1234);
		waitc(1);
		chk_val(duty[15:0], 16'h1234);
		wr(mpd_pkg::ADR_UPD_CTRL, 16'h0000);
		wr(mpd_pkg::ADR_DUTY2, 16'h5678);
		waitc(2);
		chk_val(duty[31:16], 16'h0000);
		n0 = load_n;
		pulse(1'b1);
		waitc(2);
		chk_val(duty[31:16], 16'h5678);
		wr(mpd_pkg::ADR_UPD_CTRL, 16'h0005);
		wr(mpd_pkg::ADR_DUTY1, 16'h4321);
		wr(mpd_pkg::ADR_DUTY2, 16'h9abc);
		pulse(1'b1);
		waitc(2);
		chk_val(duty[31:0], 32'h5678_1234);
		chk_cnt(load_n - n0, 1);
		wr(mpd_pkg::ADR_UPD_CTRL, 16'h0000);
		wr(mpd_pkg::ADR_OVR, 16'h00a5);
		waitc(3);
		chk_val({ph, pl}, 8'hc3);
		wr(mpd_pkg::ADR_UPD_CTRL, 16'h0002);
		wr(mpd_pkg::ADR_OVR, 16'h005a);
		waitc(3);
		chk_val({ph, pl}, 8'hc3);
		pulse(1'b1);
		waitc(3);
		chk_val({ph, pl}, 8'h3c);
		// Latched fault A on pairs 1 and 2 only
		wr(mpd_pkg::ADR_FLT_A, 16'hff03);
		req(1'b1, 1'b0);
		req(1'b0, 1'b0);
		pulse(1'b1);
		waitc(3);
		chk_val({ph, pl}, 8'h3f);
		wr(mpd_pkg::ADR_FLT_STAT, 16'h0001);
		waitc(3);
		chk_val({ph, pl}, 8'h3c);
		// Cycle-by-cycle on every pair, then both faults together
		wr(mpd_pkg::ADR_FLT_A, 16'ha58f);
		wr(mpd_pkg::ADR_FLT_B, 16'h008f);
		req(1'b1, 1'b0);
		chk_val({ph, pl}, 8'hc3);
		req(1'b0, 1'b1);
		// Fault A holds until a period start sees its pin low
		chk_val({ph, pl}, 8'hc3);
		pulse(1'b1);
		waitc(3);
		chk_val({ph, pl}, 8'h00);
		req(1'b1, 1'b1);
		chk_val({ph, pl}, 8'hc3);
		req(1'b0, 1'b0);
		pulse(1'b1);
		waitc(3);
		chk_val({ph, pl}, 8'h3c);
		// Latched fault B on pair 4 only
		wr(mpd_pkg::ADR_FLT_B, 16'h0008);
		req(1'b0, 1'b1);
		req(1'b0, 1'b0);
		pulse(1'b1);
		waitc(3);
		chk_val({ph, pl}, 8'h34);
		wr(mpd_pkg::ADR_FLT_STAT, 16'h0002);
		waitc(3);
		chk_val({ph, pl}, 8'h3c);
		wr(mpd_pkg::ADR_OVR, 16'hff00);
		ind <= 4'h2;
		gh <= 4'h2;
		gl <= 4'h2;
		// Override sync is still on: the new copy waits for a period start
		pulse(1'b1);
		waitc(5);
		chk_val({ph[1], pl[1], shoot}, 6'h30);
		wr(mpd_pkg::ADR_OVR, 16'h00ff);
		rst_i <= 1'b1;
		waitc(6);
		rst_i <= 1'b0;
		rd(mpd_pkg::ADR_OVR, 16'hff00);
		give_verdict();
	end
endmodule
